// file: common/thermal_lock_pkg.sv
package thermal_lock_pkg;

	// Register pointers seen by the serial engine
	localparam logic [7:0] PTR_CONFIG   = 8'h01;
	localparam logic [7:0] PTR_UPPER    = 8'h02;
	localparam logic [7:0] PTR_LOWER    = 8'h03;
	localparam logic [7:0] PTR_CRITICAL = 8'h04;
	localparam logic [7:0] PTR_TEMP     = 8'h05;

	// Configuration register fields
	localparam int CFG_HYST_LO  = 9;
	localparam int CFG_HYST_HI  = 10;
	localparam int CFG_SHUTDOWN = 8;
	localparam int CFG_CRIT_LCK = 7;
	localparam int CFG_WIN_LCK  = 6;

	// Temperature register fields
	localparam int TEMP_W       = 13;
	localparam int TEMP_CRIT    = 15;
	localparam int TEMP_ABOVE   = 14;
	localparam int TEMP_BELOW   = 13;

	localparam logic [1:0] HYST_RST = 2'h0;
	localparam logic [TEMP_W-1:0] THRESH_RST = 13'h0000;

	// Hysteresis in LSB of 1/16 degree
	localparam logic [TEMP_W:0] HYST_NONE = 14'h0000;
	localparam logic [TEMP_W:0] HYST_1P5  = 14'h0018;
	localparam logic [TEMP_W:0] HYST_3    = 14'h0030;
	localparam logic [TEMP_W:0] HYST_6    = 14'h0060;

	// Conversion period: ten conversions a second
	localparam int CONV_PERIOD_NS = 100_000_000;
	localparam int CLK_PERIOD_NS  = 10;
	localparam int CONV_CYCLES    = CONV_PERIOD_NS / CLK_PERIOD_NS;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic crit;
		logic above;
		logic below;
	} alarm_flags_t;

	typedef enum logic [1:0] {
		PH_OFF,
		PH_FIRST,
		PH_SECOND,
		PH_TRACK
	} conv_phase_t;

endpackage

// file: logic/thermal_shutdown_lock_ctrl.sv
`timescale 1ns/10ps
module thermal_shutdown_lock_ctrl #(
	parameter int CONV_CYCLES_P = thermal_lock_pkg::CONV_CYCLES
) (
	input  wire logic                       i_clk,
	input  wire logic                       i_rstn,
	input  wire thermal_lock_pkg::reg_req_t i_req,
	input  wire logic [12:0]                i_adc_temp,
	output logic      [15:0]                o_reg_rdata,
	output logic                            o_reg_rvalid,
	output logic                            o_sensor_en,
	output logic                            o_event_out,
	output logic                            o_event_oe
);
	import thermal_lock_pkg::*;

	function automatic logic [TEMP_W:0] sx(input logic [TEMP_W-1:0] v);
		sx = {v[TEMP_W-1], v};
	endfunction

	function automatic logic [TEMP_W:0] hyst_of(input logic [1:0] sel);
		unique case (sel)
			2'h0: hyst_of = HYST_NONE;
			2'h1: hyst_of = HYST_1P5;
			2'h2: hyst_of = HYST_3;
			2'h3: hyst_of = HYST_6;
		endcase
	endfunction

	// Signed a > b on sign-extended operands
	function automatic logic gt(input logic [TEMP_W:0] a,
		input logic [TEMP_W:0] b);
		gt = $signed(a) > $signed(b);
	endfunction

	// Configuration and threshold state
	logic [1:0]        hyst_sel;
	logic              shutdown;
	logic              crit_lock;
	logic              win_lock;
	logic [TEMP_W-1:0] upper;
	logic [TEMP_W-1:0] lower;
	logic [TEMP_W-1:0] critical;
	logic [1:0]        next_hyst_sel;
	logic              next_shutdown;
	logic              next_crit_lock;
	logic              next_win_lock;
	logic [TEMP_W-1:0] next_upper;
	logic [TEMP_W-1:0] next_lower;
	logic [TEMP_W-1:0] next_critical;
	logic              cfg_wr;

	always_comb begin
		next_hyst_sel  = hyst_sel;
		next_shutdown  = shutdown;
		next_crit_lock = crit_lock;
		next_win_lock  = win_lock;
		next_upper     = upper;
		next_lower     = lower;
		next_critical  = critical;
		cfg_wr = i_req.wr && (i_req.addr == PTR_CONFIG);
		if (cfg_wr) begin
			next_hyst_sel = i_req.wdata[CFG_HYST_HI:CFG_HYST_LO];
			// Locks only ever set; no path back to zero but reset
			next_crit_lock = crit_lock | i_req.wdata[CFG_CRIT_LCK];
			next_win_lock  = win_lock | i_req.wdata[CFG_WIN_LCK];
			if (!i_req.wdata[CFG_SHUTDOWN])
				next_shutdown = 1'b0;
			else if (!crit_lock && !win_lock)
				next_shutdown = 1'b1;
		end
		if (i_req.wr && !win_lock) begin
			if (i_req.addr == PTR_UPPER)
				next_upper = i_req.wdata[TEMP_W-1:0];
			if (i_req.addr == PTR_LOWER)
				next_lower = i_req.wdata[TEMP_W-1:0];
		end
		if (i_req.wr && !crit_lock && i_req.addr == PTR_CRITICAL)
			next_critical = i_req.wdata[TEMP_W-1:0];
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			hyst_sel  <= HYST_RST;
			shutdown  <= 1'b0;
			crit_lock <= 1'b0;
			win_lock  <= 1'b0;
			upper     <= THRESH_RST;
			lower     <= THRESH_RST;
			critical  <= THRESH_RST;
		end else begin
			hyst_sel  <= next_hyst_sel;
			shutdown  <= next_shutdown;
			crit_lock <= next_crit_lock;
			win_lock  <= next_win_lock;
			upper     <= next_upper;
			lower     <= next_lower;
			critical  <= next_critical;
		end
	end

	// Analog result arrives from outside the clock domain. The word is only
	// taken once two synced samples agree, so a code caught mid-change never
	// reaches the comparators; costs two cycles of latency.
	logic [TEMP_W-1:0] adc_meta;
	logic [TEMP_W-1:0] adc_sync;
	logic [TEMP_W-1:0] adc_prev;
	logic [TEMP_W-1:0] adc_word;
	logic [TEMP_W-1:0] next_adc_word;

	always_comb begin
		next_adc_word = adc_word;
		if (adc_sync == adc_prev)
			next_adc_word = adc_sync;
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			adc_meta <= THRESH_RST;
			adc_sync <= THRESH_RST;
			adc_prev <= THRESH_RST;
			adc_word <= THRESH_RST;
		end else begin
			adc_meta <= i_adc_temp;
			adc_sync <= adc_meta;
			adc_prev <= adc_sync;
			adc_word <= next_adc_word;
		end
	end

	// Conversion timebase and alarm tracking
	logic [31:0]       div_cnt;
	logic              conv_tick;
	conv_phase_t       phase;
	logic [TEMP_W-1:0] temp;
	alarm_flags_t      flags;
	logic              event_act;
	logic [31:0]       next_div_cnt;
	logic              next_conv_tick;
	conv_phase_t       next_phase;
	logic [TEMP_W-1:0] next_temp;
	alarm_flags_t      next_flags;
	logic              next_event_act;
	logic [TEMP_W:0]   t_new;
	logic [TEMP_W:0]   hyst;
	logic              falling;

	always_comb begin
		next_div_cnt   = div_cnt;
		next_conv_tick = 1'b0;
		next_phase     = phase;
		next_temp      = temp;
		next_flags     = flags;
		next_event_act = event_act;
		t_new   = sx(adc_word);
		hyst    = hyst_of(hyst_sel);
		falling = gt(sx(temp), t_new);
		if (shutdown) begin
			// Timebase parked so the first sample after exit is a full one
			next_div_cnt   = 32'h0;
			next_phase     = PH_OFF;
			next_event_act = 1'b0;
		end else if (phase == PH_OFF) begin
			next_flags     = '0;
			next_event_act = 1'b0;
			next_phase     = PH_FIRST;
		end else begin
			if (div_cnt == 32'(CONV_CYCLES_P - 1)) begin
				next_div_cnt   = 32'h0;
				next_conv_tick = 1'b1;
			end else begin
				next_div_cnt = div_cnt + 32'h1;
			end
			if (conv_tick) begin
				next_temp = adc_word;
				unique case (phase)
					PH_FIRST: begin
						// Flags were cleared, so only below can use hysteresis
						next_flags.crit  = gt(t_new, sx(critical));
						next_flags.above = gt(t_new, sx(upper));
						next_flags.below = !gt(t_new,
							14'(sx(lower) - hyst));
						next_phase = PH_SECOND;
					end
					default: begin
						if (falling) begin
							next_flags.crit = flags.crit ?
								gt(t_new, 14'(sx(critical) - hyst)) :
								gt(t_new, sx(critical));
							next_flags.above = flags.above ?
								gt(t_new, 14'(sx(upper) - hyst)) :
								gt(t_new, sx(upper));
							next_flags.below = flags.below |
								!gt(t_new, 14'(sx(lower) - hyst));
						end else begin
							next_flags.crit  = gt(t_new, sx(critical));
							next_flags.above = gt(t_new, sx(upper));
							next_flags.below = gt(sx(lower), t_new);
						end
						next_phase = PH_TRACK;
					end
				endcase
			end
			next_event_act = |next_flags;
			if (phase == PH_FIRST && !conv_tick)
				next_event_act = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			div_cnt   <= 32'h0;
			conv_tick <= 1'b0;
			phase     <= PH_OFF;
			temp      <= THRESH_RST;
			flags     <= '0;
			event_act <= 1'b0;
		end else begin
			div_cnt   <= next_div_cnt;
			conv_tick <= next_conv_tick;
			phase     <= next_phase;
			temp      <= next_temp;
			flags     <= next_flags;
			event_act <= next_event_act;
		end
	end

	// Read port; answers in shutdown too
	logic [15:0] next_rdata;
	logic [15:0] cfg_view;
	logic [15:0] temp_view;

	always_comb begin
		cfg_view = 16'h0000;
		cfg_view[CFG_HYST_HI:CFG_HYST_LO] = hyst_sel;
		cfg_view[CFG_SHUTDOWN] = shutdown;
		cfg_view[CFG_CRIT_LCK] = crit_lock;
		cfg_view[CFG_WIN_LCK]  = win_lock;
		temp_view = {3'h0, temp};
		temp_view[TEMP_CRIT]  = flags.crit;
		temp_view[TEMP_ABOVE] = flags.above;
		temp_view[TEMP_BELOW] = flags.below;
		next_rdata = o_reg_rdata;
		if (i_req.rd) begin
			unique case (i_req.addr)
				PTR_CONFIG:   next_rdata = cfg_view;
				PTR_UPPER:    next_rdata = {3'h0, upper};
				PTR_LOWER:    next_rdata = {3'h0, lower};
				PTR_CRITICAL: next_rdata = {3'h0, critical};
				PTR_TEMP:     next_rdata = temp_view;
				default:      next_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_reg_rdata  <= 16'h0000;
			o_reg_rvalid <= 1'b0;
			o_sensor_en  <= 1'b0;
			o_event_out  <= 1'b0;
			o_event_oe   <= 1'b0;
		end else begin
			o_reg_rdata  <= next_rdata;
			o_reg_rvalid <= i_req.rd;
			o_sensor_en  <= !next_shutdown;
			o_event_out  <= 1'b0;
			o_event_oe   <= next_event_act;
		end
	end

endmodule

// file: bench/lock_ctrl_props.sv
`timescale 1ns/10ps
module lock_ctrl_props #(
	parameter int CONV_CYCLES_P = 20
) (
	input wire logic                       i_clk,
	input wire logic                       i_rstn,
	input wire thermal_lock_pkg::reg_req_t i_req,
	input wire logic [12:0]                i_adc_temp,
	input wire logic [15:0]                o_reg_rdata,
	input wire logic                       o_reg_rvalid,
	input wire logic                       o_sensor_en,
	input wire logic                       o_event_out,
	input wire logic                       o_event_oe
);
	import thermal_lock_pkg::*;
	logic locked;
	logic next_locked;
	logic cfg_wr;
	assign cfg_wr = i_req.wr && i_req.addr == PTR_CONFIG;
	// Both locks are sticky, so any write that sets one keeps it
	always_comb begin
		next_locked = locked | (cfg_wr & (|i_req.wdata[7:6]));
	end
	always_ff @(posedge i_clk) begin
		locked <= i_rstn ? next_locked : 1'b0;
	end
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);
	a_read_answer: assert property (i_req.rd |=> o_reg_rvalid)
		else $error("read not answered");
	a_answer_cause: assert property (o_reg_rvalid |-> $past(i_req.rd))
		else $error("answer without read");
	a_pin_low_only: assert property (o_event_out == 1'b0)
		else $error("alert pin driven high");
	a_quiet_shutdown: assert property
		(!o_sensor_en && $past(!o_sensor_en) |-> !o_event_oe)
		else $error("alert during shutdown");
	a_exit_quiet: assert property ($rose(o_sensor_en) |-> !o_event_oe [*8])
		else $error("alert right after shutdown exit");
	a_lock_refuse: assert property
		(cfg_wr && i_req.wdata[8] && locked && o_sensor_en |=> o_sensor_en)
		else $error("shutdown taken while locked");
	a_clear_taken: assert property (cfg_wr && !i_req.wdata[8] |=> o_sensor_en)
		else $error("shutdown clear refused");
	a_shutdown_taken: assert property
		(cfg_wr && i_req.wdata[8] && !locked && !(|i_req.wdata[7:6])
		|=> !o_sensor_en)
		else $error("shutdown not entered");
	a_sensor_hold: assert property
		($past(i_rstn) && !cfg_wr |=> $stable(o_sensor_en))
		else $error("sensor enable changed unasked");
endmodule
bind thermal_shutdown_lock_ctrl lock_ctrl_props #(
	.CONV_CYCLES_P(CONV_CYCLES_P)
) props (
	.i_clk(i_clk),
	.i_rstn(i_rstn),
	.i_req(i_req),
	.i_adc_temp(i_adc_temp),
	.o_reg_rdata(o_reg_rdata),
	.o_reg_rvalid(o_reg_rvalid),
	.o_sensor_en(o_sensor_en),
	.o_event_out(o_event_out),
	.o_event_oe(o_event_oe)
);

// file: bench/host_model.sv
`timescale 1ns/10ps
module host_model (
	input  wire logic                  i_clk,
	input  wire logic                  i_rvalid,
	input  wire logic [15:0]           i_rdata,
	output thermal_lock_pkg::reg_req_t o_req
);
	import thermal_lock_pkg::*;
	initial o_req = '0;
	// A lock takes one plain write, never a confirming second one
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge i_clk);
		o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge i_clk);
		o_req = '0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d,
		output logic ok);
		int n;
		@(negedge i_clk);
		o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(negedge i_clk);
		o_req = '0;
		n = 0;
		while (i_rvalid !== 1'b1 && n < 4) begin
			@(negedge i_clk);
			n++;
		end
		ok = (i_rvalid === 1'b1);
		d = i_rdata;
	endtask
endmodule

// file: bench/tb.sv
`timescale 1ns/10ps
module tb;
	import thermal_lock_pkg::*;
	localparam int CONV = 20;
	logic        i_clk = 1'b0;
	logic        i_rstn = 1'b0;
	logic [12:0] adc = 13'h0200;
	reg_req_t    req;
	logic [15:0] rdata;
	logic        rvalid;
	logic        sen;
	logic        ev_oe;
	logic        ev_out;
	int          miscompares = 0;
	int          tests_run = 0;
	always #5 i_clk = ~i_clk;
	thermal_shutdown_lock_ctrl #(.CONV_CYCLES_P(CONV)) dut (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_req(req),
		.i_adc_temp(adc),
		.o_reg_rdata(rdata),
		.o_reg_rvalid(rvalid),
		.o_sensor_en(sen),
		.o_event_out(ev_out),
		.o_event_oe(ev_oe)
	);
	host_model host (
		.i_clk(i_clk),
		.i_rvalid(rvalid),
		.i_rdata(rdata),
		.o_req(req)
	);
	task automatic results;
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] d;
		logic        ok;
		host.rd(a, d, ok);
		if (!ok) begin
			miscompares++;
			$display("mismatch at %0t: rvalid %h expected %h", $time,
				1'b0, 1'b1);
			results();
		end else begin
			chk(d, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	initial begin
		idle(5);
		i_rstn = 1'b1;
		rd(PTR_CONFIG, 16'h0000);
		chk({15'h0, sen}, 16'h0001);
		rd(8'h7e, 16'h0000);
		host.wr(PTR_UPPER, 16'h0100);
		host.wr(PTR_LOWER, 16'h0000);
		host.wr(PTR_CRITICAL, 16'h0300);
		rd(PTR_CRITICAL, 16'h0300);
		idle(3 * CONV);
		rd(PTR_TEMP, 16'h4200);
		chk({14'h0, ev_out, ev_oe}, 16'h0001);
		host.wr(PTR_CONFIG, 16'h0100);
		idle(2);
		chk({14'h0, sen, ev_oe}, 16'h0000);
		adc = 13'h0050;
		idle(3 * CONV);
		rd(PTR_TEMP, 16'h4200);
		rd(PTR_CONFIG, 16'h0100);
		// Lower limit sits inside the 6 degree band above the new reading
		host.wr(PTR_LOWER, 16'h0060);
		host.wr(PTR_CONFIG, 16'h0700);
		rd(PTR_CONFIG, 16'h0700);
		rd(PTR_LOWER, 16'h0060);
		host.wr(PTR_CONFIG, 16'h0600);
		rd(PTR_TEMP, 16'h0200);
		idle(CONV);
		rd(PTR_TEMP, 16'h0050);
		chk({15'h0, ev_oe}, 16'h0000);
		// A falling second sample keeps hysteresis on the lower limit
		adc = 13'h0040;
		idle(CONV);
		rd(PTR_TEMP, 16'h0040);
		idle(CONV);
		rd(PTR_TEMP, 16'h2040);
		chk({15'h0, ev_oe}, 16'h0001);
		for (int h = 0; h < 4; h++) begin
			host.wr(PTR_CONFIG, {5'h0, h[1:0], 9'h0});
			rd(PTR_CONFIG, {5'h0, h[1:0], 9'h0});
		end
		host.wr(PTR_CONFIG, 16'h0080);
		rd(PTR_CONFIG, 16'h0080);
		host.wr(PTR_CRITICAL, 16'h0100);
		rd(PTR_CRITICAL, 16'h0300);
		host.wr(PTR_CONFIG, 16'h0000);
		rd(PTR_CONFIG, 16'h0080);
		host.wr(PTR_CONFIG, 16'h0580);
		idle(2);
		chk({15'h0, sen}, 16'h0001);
		rd(PTR_CONFIG, 16'h0480);
		host.wr(PTR_CONFIG, 16'h04c0);
		host.wr(PTR_UPPER, 16'h0040);
		rd(PTR_UPPER, 16'h0100);
		i_rstn = 1'b0;
		idle(5);
		i_rstn = 1'b1;
		rd(PTR_CONFIG, 16'h0000);
		host.wr(PTR_CONFIG, 16'h0040);
		host.wr(PTR_CONFIG, 16'h0140);
		idle(2);
		chk({15'h0, sen}, 16'h0001);
		rd(PTR_CONFIG, 16'h0040);
		host.wr(PTR_LOWER, 16'h0010);
		rd(PTR_LOWER, 16'h0000);
		results();
	end
endmodule
